/* logic/wheel_pkg.sv */
// Shared constants and bus carrier types for the wheel step decoder.
package wheel_pkg;

   ////////////////////////////////////////////////////////////////////////
   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned IDX_W = 10;
   localparam int unsigned REG_W = 8;
   localparam int unsigned PIN_COUNT = 8;
   localparam int unsigned SEL_W = 3;
   localparam int unsigned WIN_W = 3;
   localparam int unsigned PHASES = 2;

   // Register indexes; the byte address of each is four times its index.
   localparam logic [IDX_W-1:0] IDX_SYS_RESET = 10'h060;
   localparam logic [IDX_W-1:0] IDX_SNAPSHOT = 10'h0D0;
   localparam logic [IDX_W-1:0] IDX_FILTER_CFG = 10'h0D1;
   localparam logic [IDX_W-1:0] IDX_SEL_A = 10'h0D2;
   localparam logic [IDX_W-1:0] IDX_SEL_B = 10'h0D3;
   localparam logic [IDX_W-1:0] IDX_MODE = 10'h0D7;
   localparam logic [IDX_W-1:0] IDX_LOAD = 10'h0D8;

   // Field positions.
   localparam int unsigned WIN_LSB = 0;
   localparam int unsigned POLA_BIT = 4;
   localparam int unsigned SHUTTLE_BIT = 5;
   localparam int unsigned SEL_LSB = 0;
   localparam int unsigned MODE_BIT = 0;
   localparam int unsigned LOAD_BIT = 0;
   localparam int unsigned DEC_RST_BIT = 5;
   localparam int unsigned BYTE_LANE0 = 0;

   // Reset values.
   localparam logic [WIN_W-1:0] RST_WIN = 3'h0;
   localparam logic RST_POLA = 1'b0;
   localparam logic RST_SHUTTLE = 1'b0;
   localparam logic [SEL_W-1:0] RST_SEL_A = 3'h0;
   localparam logic [SEL_W-1:0] RST_SEL_B = 3'h1;
   localparam logic RST_MODE = 1'b1;
   localparam logic RST_LOAD = 1'b0;
   localparam logic RST_DEC_RST = 1'b0;
   localparam logic [REG_W-1:0] RST_SNAPSHOT = 8'h00;

   // Timing: the slow decoder tick stands for the 32 kHz clock.
   localparam int unsigned SLOW_CLK_PERIOD_NS = 31250;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
      logic [3:0] pstrb;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic [DATA_W-1:0] prdata;
      logic pslverr;
   } apb_rsp_t;

endpackage

/* logic/phase_filter.sv */
// Debounce filter that rebuilds a clean level from one synchronised phase input.
`timescale 1ns/100ps
module phase_filter (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire logic tick,
   input wire logic [wheel_pkg::WIN_W-1:0] win,
   input wire logic raw,
   output logic clean
);
   import wheel_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   localparam int unsigned CNT_W = 10;
   localparam int unsigned JITTER_MULT = 3;

   logic [CNT_W-1:0] hold_reg;
   logic [CNT_W-1:0] hold_next;
   logic [CNT_W-1:0] window;
   logic [WIN_W:0] shift_amt;
   logic clean_reg;
   logic differs;
   logic accept;

   // A new level must stand for three times 2^(win+1) slow ticks before it is taken.
   // The shift amount is one bit wider so that the largest field does not wrap.
   assign shift_amt = {1'b0, win} + (WIN_W + 1)'(1);
   assign window = (CNT_W'(1) << shift_amt) * CNT_W'(JITTER_MULT);
   assign differs = raw != clean_reg;
   assign hold_next = hold_reg + CNT_W'(1);
   assign accept = differs && tick && (hold_next == window);
   assign clean = clean_reg;

   ////////////////////////////////////////////////////////////////////////
   // A glitch that falls back before the window ends restarts the count.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hold_reg <= '0;
         clean_reg <= 1'b0;
      end else if (ce) begin
         if (!differs || accept) begin
            hold_reg <= '0;
         end else if (tick) begin
            hold_reg <= hold_next;
         end
         if (accept) begin
            clean_reg <= raw;
         end
      end
   end

endmodule

/* logic/wheel_step_decoder.sv */
// Quadrature wheel step decoder with APB register access and count snapshot.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
module wheel_step_decoder #(
   parameter int unsigned CORE_PERIOD_NS = 100,
   parameter int unsigned COUNT_W = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire wheel_pkg::apb_req_t apb_req,
   output wheel_pkg::apb_rsp_t apb_rsp,
   input wire logic [wheel_pkg::PIN_COUNT-1:0] port_pins
);
   import wheel_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // The 32 kHz rate is made as a one-cycle tick from the core clock.
   localparam int unsigned TICK_DIV = SLOW_CLK_PERIOD_NS / CORE_PERIOD_NS;
   localparam int unsigned TICK_W = 16;

   generate
      if (TICK_DIV < 1 || TICK_DIV > 65535) begin : g_bad_period
         $error("CORE_PERIOD_NS does not give a usable slow tick divider.");
      end
      if (COUNT_W < 1 || COUNT_W > REG_W) begin : g_bad_width
         $error("COUNT_W must lie between 1 and the register width.");
      end
   endgenerate

   function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [IDX_W-1:0] idx);
      idx_hit = (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'b00);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Configuration and status registers.
   logic [WIN_W-1:0] win_reg;
   logic pola_reg;
   logic shuttle_reg;
   logic [SEL_W-1:0] sel_a_reg;
   logic [SEL_W-1:0] sel_b_reg;
   logic mode_reg;
   logic load_reg;
   logic dec_rst_reg;
   logic [REG_W-1:0] step_count_snapshot_reg;
   logic [COUNT_W-1:0] step_count_value_reg;
   logic [COUNT_W-1:0] step_count_value_next;
   apb_rsp_t rsp_reg;

   // Pin synchronisers and slow tick.
   logic [PIN_COUNT-1:0] sync1_reg;
   logic [PIN_COUNT-1:0] sync2_reg;
   logic [PIN_COUNT-1:0] sync3_reg;
   logic [PIN_COUNT-1:0] pin_level_reg;
   logic [TICK_W-1:0] tick_cnt_reg;
   logic tick_reg;

   // Phase path.
   logic [PHASES-1:0] phase_raw;
   logic [PHASES-1:0] phase_clean;
   logic [PHASES-1:0] phase_prev_reg;
   logic [PHASES-1:0] phase_chg;
   logic [PHASES-1:0] phase_rise;
   logic last_rise_b_reg;
   logic phase_a;
   logic phase_b;
   logic same_level;
   logic lone_edge;
   logic dbl_up;
   logic dbl_dn;
   logic com_up;
   logic com_dn;
   logic shu_up;
   logic shu_dn;
   logic quad_up;
   logic quad_dn;
   logic step_up;
   logic step_dn;

   // Bus decode.
   logic setup_phase;
   logic access_done;
   logic wr_done;
   logic rd_done;
   logic hit_sys;
   logic hit_snap;
   logic hit_cfg;
   logic hit_sel_a;
   logic hit_sel_b;
   logic hit_mode;
   logic hit_load;
   logic mapped;
   logic wr_lane0;
   logic [REG_W-1:0] wbyte;
   logic [REG_W-1:0] rd_byte;
   logic [DATA_W-1:0] rd_word;

   ////////////////////////////////////////////////////////////////////////
   // Pins come from outside the clock domain: three flops, and a new level
   // counts only once the second and third flops agree.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
      end else if (ce) begin
         sync1_reg <= port_pins;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   genvar p;
   generate
      for (p = 0; p < PIN_COUNT; p++) begin : g_pin
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               pin_level_reg[p] <= 1'b0;
            end else if (ce && (sync2_reg[p] == sync3_reg[p])) begin
               pin_level_reg[p] <= sync3_reg[p];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Filter counts and clean levels step only on this tick and the step count one cycle after it, so the decoder
   // behaves the same as one clocked from the slow suspend clock.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         tick_cnt_reg <= '0;
         tick_reg <= 1'b0;
      end else if (ce) begin
         tick_reg <= (tick_cnt_reg == TICK_W'(TICK_DIV - 1));
         if (tick_cnt_reg == TICK_W'(TICK_DIV - 1)) begin
            tick_cnt_reg <= '0;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + TICK_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin choice and polarity: inside the filter the idle level is always 0.
   assign phase_raw[0] = pin_level_reg[sel_a_reg] ^ pola_reg;
   assign phase_raw[1] = pin_level_reg[sel_b_reg] ^ pola_reg;

   genvar ph;
   generate
      for (ph = 0; ph < PHASES; ph++) begin : g_phase
         phase_filter u_filter (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .ce(ce),
            .tick(tick_reg),
            .win(win_reg),
            .raw(phase_raw[ph]),
            .clean(phase_clean[ph])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Step direction. Edges on both phases in one tick break the spacing the
   // encoder must keep and are ignored rather than guessed at.
   assign phase_chg = phase_clean ^ phase_prev_reg;
   assign phase_rise = phase_clean & ~phase_prev_reg;
   assign phase_a = phase_clean[0];
   assign phase_b = phase_clean[1];
   assign same_level = phase_a == phase_b;
   assign lone_edge = phase_chg[0] ^ phase_chg[1];
   assign dbl_up = (phase_chg[0] && !same_level) || (phase_chg[1] && same_level);
   assign dbl_dn = (phase_chg[0] && same_level) || (phase_chg[1] && !same_level);
   assign com_up = phase_chg[1] && same_level;
   assign com_dn = phase_chg[0] && same_level;
   assign quad_up = lone_edge && (mode_reg ? dbl_up : com_up);
   assign quad_dn = lone_edge && (mode_reg ? dbl_dn : com_dn);
   // Shuttle: a pulse on b after one on a is a step up, the reverse is down.
   assign shu_up = phase_rise[1] && !phase_rise[0] && !last_rise_b_reg;
   assign shu_dn = phase_rise[0] && !phase_rise[1] && last_rise_b_reg;
   assign step_up = shuttle_reg ? shu_up : quad_up;
   assign step_dn = shuttle_reg ? shu_dn : quad_dn;

   always_comb begin
      step_count_value_next = step_count_value_reg;
      if (dec_rst_reg) begin
         step_count_value_next = '0;
      end else if (step_up) begin
         step_count_value_next = step_count_value_reg + COUNT_W'(1);
      end else if (step_dn) begin
         step_count_value_next = step_count_value_reg - COUNT_W'(1);
      end
   end

   // The live count sits only here and never reaches the read mux.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_prev_reg <= '0;
         last_rise_b_reg <= 1'b1;
         step_count_value_reg <= '0;
      end else if (ce) begin
         phase_prev_reg <= phase_clean;
         step_count_value_reg <= step_count_value_next;
         if (phase_rise[0] != phase_rise[1]) begin
            last_rise_b_reg <= phase_rise[1];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: the answer is registered at the setup edge, so the access
   // phase completes in its first cycle.
   assign setup_phase = apb_req.psel && !apb_req.penable;
   assign access_done = apb_req.psel && apb_req.penable && rsp_reg.pready;
   assign hit_sys = idx_hit(apb_req.paddr, IDX_SYS_RESET);
   assign hit_snap = idx_hit(apb_req.paddr, IDX_SNAPSHOT);
   assign hit_cfg = idx_hit(apb_req.paddr, IDX_FILTER_CFG);
   assign hit_sel_a = idx_hit(apb_req.paddr, IDX_SEL_A);
   assign hit_sel_b = idx_hit(apb_req.paddr, IDX_SEL_B);
   assign hit_mode = idx_hit(apb_req.paddr, IDX_MODE);
   assign hit_load = idx_hit(apb_req.paddr, IDX_LOAD);
   assign mapped = hit_sys || hit_snap || hit_cfg || hit_sel_a || hit_sel_b
      || hit_mode || hit_load;
   assign wr_done = access_done && apb_req.pwrite && mapped;
   assign rd_done = access_done && !apb_req.pwrite && mapped;
   assign wr_lane0 = wr_done && apb_req.pstrb[BYTE_LANE0];
   assign wbyte = apb_req.pwdata[REG_W-1:0];

   always_comb begin
      rd_byte = '0;
      if (hit_snap) begin
         rd_byte = step_count_snapshot_reg;
      end else if (hit_cfg) begin
         rd_byte[WIN_LSB +: WIN_W] = win_reg;
         rd_byte[POLA_BIT] = pola_reg;
         rd_byte[SHUTTLE_BIT] = shuttle_reg;
      end else if (hit_sel_a) begin
         rd_byte[SEL_LSB +: SEL_W] = sel_a_reg;
      end else if (hit_sel_b) begin
         rd_byte[SEL_LSB +: SEL_W] = sel_b_reg;
      end else if (hit_mode) begin
         rd_byte[MODE_BIT] = mode_reg;
      end else if (hit_load) begin
         rd_byte[LOAD_BIT] = load_reg;
      end else if (hit_sys) begin
         rd_byte[DEC_RST_BIT] = dec_rst_reg;
      end
   end

   assign rd_word = {{(DATA_W - REG_W){1'b0}}, rd_byte};
   assign apb_rsp = rsp_reg;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rsp_reg <= '0;
      end else if (ce) begin
         if (setup_phase) begin
            rsp_reg.pready <= 1'b1;
            rsp_reg.prdata <= apb_req.pwrite ? '0 : rd_word;
            rsp_reg.pslverr <= !mapped;
         end else if (access_done) begin
            rsp_reg <= '0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         win_reg <= RST_WIN;
         pola_reg <= RST_POLA;
         shuttle_reg <= RST_SHUTTLE;
         sel_a_reg <= RST_SEL_A;
         sel_b_reg <= RST_SEL_B;
         mode_reg <= RST_MODE;
         dec_rst_reg <= RST_DEC_RST;
      end else if (ce && wr_lane0) begin
         if (hit_cfg) begin
            win_reg <= wbyte[WIN_LSB +: WIN_W];
            pola_reg <= wbyte[POLA_BIT];
            shuttle_reg <= wbyte[SHUTTLE_BIT];
         end
         if (hit_sel_a) begin
            sel_a_reg <= wbyte[SEL_LSB +: SEL_W];
         end
         if (hit_sel_b) begin
            sel_b_reg <= wbyte[SEL_LSB +: SEL_W];
         end
         if (hit_mode) begin
            mode_reg <= wbyte[MODE_BIT];
         end
         if (hit_sys) begin
            dec_rst_reg <= wbyte[DEC_RST_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Load and read-clear. A new load request wins over the completion of an
   // earlier one, and a copy wins over a read-clear in the same cycle, so
   // neither event is lost. Writing zero to the load bit cannot cancel it.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         load_reg <= RST_LOAD;
         step_count_snapshot_reg <= RST_SNAPSHOT;
      end else if (ce) begin
         if (wr_lane0 && hit_load && wbyte[LOAD_BIT]) begin
            load_reg <= 1'b1;
         end else if (load_reg) begin
            load_reg <= 1'b0;
         end
         if (load_reg) begin
            step_count_snapshot_reg <= REG_W'(step_count_value_reg);
         end else if (rd_done && hit_snap) begin
            step_count_snapshot_reg <= '0;
         end
      end
   end

endmodule

/* tb/wheel_checker.sv */
// Bind-attached bus and register assertions for the wheel step decoder.
`timescale 1ns/100ps
module wheel_checker #(
   parameter int unsigned CORE_PERIOD_NS = 100,
   parameter int unsigned COUNT_W = 8
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic ce,
   input wire wheel_pkg::apb_req_t apb_req,
   input wire wheel_pkg::apb_rsp_t apb_rsp,
   input wire logic [wheel_pkg::PIN_COUNT-1:0] port_pins
);
   import wheel_pkg::*;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);
   wire logic [IDX_W-1:0] idx = apb_req.paddr[ADDR_W-1:2];
   wire logic al = apb_req.paddr[1:0] == 2'h0;
   wire logic setup = apb_req.psel && !apb_req.penable && ce;
   wire logic done = apb_req.psel && apb_req.penable && apb_rsp.pready && ce;
   wire logic wr_ok = done && al && apb_req.pwrite && apb_req.pstrb[BYTE_LANE0];
   wire logic rd_ok = done && al && !apb_req.pwrite;
   wire logic mapped = al && (idx == IDX_SYS_RESET || idx == IDX_SNAPSHOT || idx == IDX_MODE
      || idx == IDX_LOAD || (idx >= IDX_FILTER_CFG && idx <= IDX_SEL_B));
   wire logic load_wr = wr_ok && idx == IDX_LOAD && apb_req.pwdata[LOAD_BIT];
   logic snap_zero_reg, hold_reg, mode_reg;
   logic [SEL_W-1:0] sel_a_reg;
   logic [2:0] since_reg;
   ////////////////////////////////////////////////////////////////////////
   // Shadows follow completed accesses only; the load bit may stay readable for a
   // cycle after the write, so its check waits a few cycles.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         snap_zero_reg <= 1'h1;
         hold_reg <= RST_DEC_RST;
         mode_reg <= RST_MODE;
         sel_a_reg <= RST_SEL_A;
         since_reg <= 3'h7;
      end else begin
         if (load_wr) begin
            snap_zero_reg <= hold_reg;
         end else if (rd_ok && idx == IDX_SNAPSHOT) begin
            snap_zero_reg <= 1'h1;
         end
         if (wr_ok && idx == IDX_SYS_RESET) begin
            hold_reg <= apb_req.pwdata[DEC_RST_BIT];
         end
         if (wr_ok && idx == IDX_MODE) begin
            mode_reg <= apb_req.pwdata[MODE_BIT];
         end
         if (wr_ok && idx == IDX_SEL_A) begin
            sel_a_reg <= apb_req.pwdata[SEL_W-1:0];
         end
         if (load_wr) begin
            since_reg <= 3'h0;
         end else if (ce && since_reg != 3'h7) begin
            since_reg <= since_reg + 3'h1;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////
   chk_ready_after_setup: assert property (setup |=> apb_rsp.pready)
      else $error("pready missing after setup");
   chk_ready_drops: assert property (done |=> !apb_rsp.pready)
      else $error("pready held after completion");
   chk_idle_quiet: assert property (!apb_req.psel [*2] |->
      !apb_rsp.pready && !apb_rsp.pslverr && apb_rsp.prdata == '0)
      else $error("response not quiet while idle");
   chk_upper_zero: assert property (apb_rsp.prdata[DATA_W-1:REG_W] == '0)
      else $error("upper read data not zero");
   chk_unmapped_error: assert property (
      setup && !mapped |=> apb_rsp.pslverr && apb_rsp.prdata == '0)
      else $error("unmapped access without error");
   chk_mapped_ok: assert property (setup && mapped |=> !apb_rsp.pslverr)
      else $error("mapped access flagged as error");
   chk_snapshot_zero: assert property (
      rd_ok && idx == IDX_SNAPSHOT && snap_zero_reg |-> apb_rsp.prdata == '0)
      else $error("snapshot not zero");
   chk_sel_readback: assert property (
      rd_ok && idx == IDX_SEL_A |-> apb_rsp.prdata == DATA_W'(sel_a_reg))
      else $error("phase a selector readback wrong");
   chk_mode_readback: assert property (
      rd_ok && idx == IDX_MODE |-> apb_rsp.prdata == DATA_W'(mode_reg))
      else $error("mode readback wrong");
   chk_load_clears: assert property (
      rd_ok && idx == IDX_LOAD && since_reg >= 3'h4 |-> apb_rsp.prdata == '0)
      else $error("load bit not cleared");
   cover property (rd_ok && idx == IDX_SNAPSHOT && apb_rsp.prdata != '0);
   cover property (setup && !mapped);
   cover property (load_wr);
endmodule

bind wheel_step_decoder wheel_checker #(.CORE_PERIOD_NS(CORE_PERIOD_NS), .COUNT_W(COUNT_W))
   chk_u (.core_clk(core_clk), .arst_n(arst_n), .ce(ce), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .port_pins(port_pins));

/* tb/wheel_encoder_model.sv */
// Two-phase wheel encoder model driving the selected port pins.
`timescale 1ns/100ps
module wheel_encoder_model (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic lvl_a,
   input wire logic lvl_b,
   input wire logic pola,
   input wire logic glitch_go,
   input wire logic [7:0] glitch_len,
   input wire logic [wheel_pkg::SEL_W-1:0] sel_a,
   input wire logic [wheel_pkg::SEL_W-1:0] sel_b,
   output logic [wheel_pkg::PIN_COUNT-1:0] port_pins
);
   import wheel_pkg::*;
   logic [7:0] glitch_reg;
   logic [PIN_COUNT-1:0] noise_reg;
   // Unselected pins toggle every cycle so a wrong selector shows up as noise.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         glitch_reg <= 8'h00;
         noise_reg <= 8'h5A;
      end else begin
         noise_reg <= ~noise_reg;
         glitch_reg <= glitch_go ? glitch_len : glitch_reg - 8'(glitch_reg != 8'h00);
      end
   end
   wire logic pin_a = lvl_a ^ (glitch_reg != 8'h00) ^ pola;
   wire logic pin_b = lvl_b ^ pola;
   always_comb begin
      port_pins = noise_reg;
      port_pins[sel_b] = pin_b;
      port_pins[sel_a] = pin_a;
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench: APB register traffic and wheel motion into the decoder.
`timescale 1ns/100ps
module testbench;
   import wheel_pkg::*;
   localparam int HOLD = 500;
   logic core_clk, arst_n, ce, lvl_a, lvl_b, pola, glitch_go, err;
   logic [7:0] glitch_len;
   logic [SEL_W-1:0] sel_a, sel_b;
   logic [PIN_COUNT-1:0] port_pins;
   logic [DATA_W-1:0] rd;
   apb_req_t apb_req;
   apb_rsp_t apb_rsp;
   int n_mismatch, n_compared;
   // A longer nominal period shortens the slow tick to 31 core cycles.
   wheel_step_decoder #(.CORE_PERIOD_NS(1000), .COUNT_W(8)) dut_u (.core_clk(core_clk),
      .arst_n(arst_n), .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .port_pins(port_pins));
   wheel_encoder_model enc_u (.core_clk(core_clk), .arst_n(arst_n), .lvl_a(lvl_a),
      .lvl_b(lvl_b), .pola(pola), .glitch_go(glitch_go), .glitch_len(glitch_len),
      .sel_a(sel_a), .sel_b(sel_b), .port_pins(port_pins));
   initial begin
      core_clk = 1'h0;
      forever #50 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [DATA_W-1:0] seen,
      input logic [DATA_W-1:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] addr,
      input logic [DATA_W-1:0] wd);
      int k;
      @(posedge core_clk);
      apb_req <= '{psel: 1'h1, penable: 1'h0, pwrite: wr, paddr: addr, pwdata: wd,
         pstrb: 4'hF};
      @(posedge core_clk);
      apb_req.penable <= 1'h1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (apb_rsp.pready !== 1'h1 && k < 16);
      if (apb_rsp.pready !== 1'h1) begin
         n_mismatch++;
         report_and_stop();
      end
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic wreg(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd);
      xfer(1'h1, {idx, 2'h0}, wd);
   endtask
   task automatic rchk(input string name, input logic [IDX_W-1:0] idx,
      input logic [DATA_W-1:0] exp);
      xfer(1'h0, {idx, 2'h0}, '0);
      check(name, rd, exp);
   endtask
   task automatic load_read(input string name, input logic [REG_W-1:0] exp);
      wreg(IDX_LOAD, 32'h1);
      rchk(name, IDX_SNAPSHOT, DATA_W'(exp));
   endtask
   task automatic zero_count();
      wreg(IDX_SYS_RESET, 32'h20);
      repeat (HOLD) @(posedge core_clk);
      wreg(IDX_SYS_RESET, 32'h0);
   endtask
   // Every level is held well past the debounce window.
   task automatic move(input logic up);
      if ((lvl_a == lvl_b) == up) begin
         lvl_a <= ~lvl_a;
      end else begin
         lvl_b <= ~lvl_b;
      end
      repeat (HOLD) @(posedge core_clk);
   endtask
   task automatic pulse(input logic on_a);
      if (on_a) lvl_a <= 1'h1; else lvl_b <= 1'h1;
      repeat (HOLD) @(posedge core_clk);
      if (on_a) lvl_a <= 1'h0; else lvl_b <= 1'h0;
      repeat (HOLD) @(posedge core_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge core_clk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      {arst_n, lvl_a, lvl_b, pola, glitch_go, err} = '0;
      {ce, sel_a, sel_b, glitch_len, rd} = {1'h1, 3'h0, 3'h1, 8'h0, 32'h0};
      apb_req = '0;
      n_mismatch = 0;
      n_compared = 0;
      repeat (3) @(posedge core_clk);
      arst_n <= 1'h1;
      rchk("snapshot", IDX_SNAPSHOT, 32'h0);
      rchk("filter cfg", IDX_FILTER_CFG, 32'h0);
      rchk("sel a", IDX_SEL_A, 32'h0);
      rchk("sel b", IDX_SEL_B, 32'h1);
      rchk("mode", IDX_MODE, 32'h1);
      rchk("load", IDX_LOAD, 32'h0);
      rchk("sys reset", IDX_SYS_RESET, 32'h0);
      xfer(1'h0, {10'h0D6, 2'h0}, '0);
      check("unmapped err", DATA_W'(err), 32'h1);
      xfer(1'h0, {IDX_MODE, 2'h2}, '0);
      check("unaligned err", DATA_W'(err), 32'h1);
      wreg(IDX_SNAPSHOT, 32'hA5);
      repeat (4) move(1'h1);
      rchk("no auto copy", IDX_SNAPSHOT, 32'h0);
      wreg(IDX_LOAD, 32'h1);
      repeat (4) @(posedge core_clk);
      rchk("load bit", IDX_LOAD, 32'h0);
      rchk("double up", IDX_SNAPSHOT, 32'h4);
      rchk("read clear", IDX_SNAPSHOT, 32'h0);
      repeat (5) move(1'h0);
      load_read("wrap down", 8'hFF);
      wreg(IDX_SYS_RESET, 32'h20);
      move(1'h1);
      load_read("held", 8'h00);
      rchk("sys reset bit", IDX_SYS_RESET, 32'h20);
      wreg(IDX_SYS_RESET, 32'h0);
      wreg(IDX_MODE, 32'h0);
      repeat (4) move(1'h1);
      load_read("common up", 8'h02);
      repeat (2) move(1'h0);
      load_read("common down", 8'h01);
      wreg(IDX_MODE, 32'h1);
      for (int k = 0; k < 4; k++) begin
         wreg(IDX_SEL_A, DATA_W'(2 * k + 1));
         wreg(IDX_SEL_B, DATA_W'(2 * k));
         wreg(IDX_FILTER_CFG, DATA_W'(k % 2) << POLA_BIT);
         sel_a <= SEL_W'(2 * k + 1);
         sel_b <= SEL_W'(2 * k);
         pola <= k[0];
         zero_count();
         move(1'h1);
         move(1'h1);
         load_read("pin select", 8'h02);
      end
      lvl_a <= 1'h0;
      lvl_b <= 1'h0;
      wreg(IDX_FILTER_CFG, 32'h30);
      pulse(1'h0);
      zero_count();
      pulse(1'h1);
      pulse(1'h1);
      load_read("shuttle down", 8'hFF);
      pulse(1'h0);
      load_read("shuttle up", 8'h00);
      wreg(IDX_FILTER_CFG, 32'h01);
      pola <= 1'h0;
      zero_count();
      glitch_len <= 8'd70;
      glitch_go <= 1'h1;
      @(posedge core_clk);
      glitch_go <= 1'h0;
      repeat (HOLD) @(posedge core_clk);
      load_read("glitch", 8'h00);
      move(1'h1);
      load_read("long level", 8'h01);
      report_and_stop();
   end
endmodule
